// File: src/ips_sensor_slave.sv
/*
 * Top of the read-only sensor serial slave: answers reads at its fixed
 * address with pressure and temperature words, alternating until STOP.
 * Assumes open-drain pins resolved outside; output enables are active low.
 */
`default_nettype none
// Functional notes
// - idle bus means both lines released high
// - START is data falling while clock high
// - bus busy from START until STOP
// - STOP is data rising, clock high; idle
// - repeated START handled exactly like START
// - one bit per clock pulse, stable high
// - data changes only while clock low
// - data grouped in eight-bit bytes
// - each byte sent most significant first
// - slave may hold clock low when unready
// - each byte followed by receiver acknowledge
// - ninth pulse: transmitter releases data line
// - acknowledge is low through ninth high
// - high ninth bit means not-acknowledge
// - first byte: seven-bit address plus direction
// - respond only to address 1111000 binary
// - direction zero write, one read
// - serve only read transfers
// - acknowledge matching read, then send bytes
// - send pressure high/low, temperature high/low
// - fifteen-bit values, alternate until STOP
// - refresh values every 2.2 ms
module ips_sensor_slave
  import ips_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [IPS_VAL_BITS-1:0] press_i,
  input wire logic [IPS_VAL_BITS-1:0] temp_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic busy_o,
  output logic addressed_o,
  output logic refresh_o
);
  ips_bus_if bus ();
  ips_state_e state_reg;
  ips_state_e state_next;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [1:0] word_reg;
  logic [7:0] tx_reg;
  logic busy_reg;
  logic drive_low_reg;
  logic stretch_reg;
  logic [IPS_VAL_BITS-1:0] press_val;
  logic [IPS_VAL_BITS-1:0] temp_val;
  logic refresh_tick;
  logic [IPS_VAL_BITS-1:0] press_snap_reg;
  logic [IPS_VAL_BITS-1:0] temp_snap_reg;

  ips_pin_sync u_pins (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .bus(bus)
  );

  // values only change while no read is running, so a pair never tears
  ips_refresh u_refresh (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .hold_i(busy_reg && state_reg != IPS_IDLE),
    .press_i(press_i),
    .temp_i(temp_i),
    .press_o(press_val),
    .temp_o(temp_val),
    .tick_o(refresh_tick)
  );

  // byte selection for the four-byte cycle
  function automatic logic [7:0] pick_byte(input logic [1:0] idx,
                                           input logic [IPS_VAL_BITS-1:0] p,
                                           input logic [IPS_VAL_BITS-1:0] t);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      IPS_WORD_PH: b = {1'b0, p[IPS_VAL_BITS-1:8]};
      IPS_WORD_PL: b = p[7:0];
      IPS_WORD_TH: b = {1'b0, t[IPS_VAL_BITS-1:8]};
      IPS_WORD_TL: b = t[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  wire [7:0] addr_byte = {shift_reg[6:0], bus.sda_level};
  wire addr_match = addr_byte[7:1] == IPS_DEV_ADDR;
  wire is_read = addr_byte[0] == IPS_DIR_READ;
  wire byte_done = bit_reg == IPS_BIT_LAST;
  wire [7:0] next_tx = pick_byte(word_reg, press_snap_reg, temp_snap_reg);
  wire master_ack = !bus.sda_level;

  always_comb begin
    state_next = state_reg;
    if (bus.stop_seen) begin
      state_next = IPS_IDLE;
    end else if (bus.start_seen) begin
      state_next = IPS_ADDR;
    end else begin
      case (state_reg)
        IPS_IDLE: state_next = IPS_IDLE;
        IPS_ADDR: begin
          if (bus.scl_rise && byte_done) begin
            state_next = (addr_match && is_read) ? IPS_AACK : IPS_IDLE;
          end
        end
        IPS_AACK: begin
          // second fall ends the acknowledge pulse
          if (bus.scl_fall && drive_low_reg) begin
            state_next = IPS_SEND;
          end
        end
        IPS_SEND: begin
          // fall after the eighth rise releases the line for the ninth pulse
          if (bus.scl_fall && bit_reg == IPS_BIT_ZERO) begin
            state_next = IPS_MACK;
          end
        end
        IPS_MACK: begin
          if (bus.scl_rise && !master_ack) begin
            state_next = IPS_IDLE;
          end else if (bus.scl_fall) begin
            state_next = IPS_SEND;
          end
        end
        default: state_next = IPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= IPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus occupancy follows START and STOP for every address
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (bus.start_seen) begin
      busy_reg <= 1'b1;
    end else if (bus.stop_seen) begin
      busy_reg <= 1'b0;
    end
  end

  // bit counter and receive shifter; one bit taken per clock rise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bit_reg <= IPS_BIT_ZERO;
      shift_reg <= 8'h00;
    end else if (bus.start_seen) begin
      bit_reg <= IPS_BIT_ZERO;
      shift_reg <= 8'h00;
    end else if (bus.scl_rise && (state_reg == IPS_ADDR || state_reg == IPS_SEND)) begin
      bit_reg <= byte_done ? IPS_BIT_ZERO : bit_reg + 4'h1;
      shift_reg <= addr_byte;
    end
  end

  // word pointer restarts with each read; snapshot held for the whole read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      word_reg <= IPS_WORD_PH;
      press_snap_reg <= '0;
      temp_snap_reg <= '0;
    end else if (state_reg == IPS_ADDR && state_next == IPS_AACK) begin
      word_reg <= IPS_WORD_PH;
      press_snap_reg <= press_val;
      temp_snap_reg <= temp_val;
    end else if (state_reg == IPS_SEND && state_next == IPS_MACK) begin
      word_reg <= word_reg + 2'h1;
    end
  end

  // transmit register and data pin driver, updated on clock fall, released on START or STOP
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_reg <= 8'h00;
      drive_low_reg <= 1'b0;
    end else if (bus.start_seen || bus.stop_seen) begin
      drive_low_reg <= 1'b0;
    end else if (bus.scl_fall) begin
      case (state_reg)
        IPS_ADDR: drive_low_reg <= 1'b0;
        IPS_AACK: begin
          if (!drive_low_reg) begin
            drive_low_reg <= 1'b1;
          end else begin
            drive_low_reg <= !next_tx[7];
            tx_reg <= {next_tx[6:0], 1'b0};
          end
        end
        IPS_SEND: begin
          if (bit_reg == IPS_BIT_ZERO) begin
            drive_low_reg <= 1'b0;
          end else begin
            drive_low_reg <= !tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        IPS_MACK: begin
          if (state_next == IPS_SEND) begin
            drive_low_reg <= !next_tx[7];
            tx_reg <= {next_tx[6:0], 1'b0};
          end else begin
            drive_low_reg <= 1'b0;
          end
        end
        default: drive_low_reg <= 1'b0;
      endcase
    end
  end

  // clock held low for one cycle, two cycles after a refresh latch while the bus is busy and this slave idle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stretch_reg <= 1'b0;
    end else begin
      stretch_reg <= refresh_tick && state_reg == IPS_IDLE && busy_reg && !bus.scl_level;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
      scl_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      busy_o <= 1'b0;
      addressed_o <= 1'b0;
      refresh_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n_o <= !(drive_low_reg && state_reg != IPS_IDLE);
      scl_o <= 1'b0;
      scl_oe_n_o <= !stretch_reg;
      busy_o <= busy_reg;
      addressed_o <= state_reg != IPS_IDLE && state_reg != IPS_ADDR;
      refresh_o <= refresh_tick;
    end
  end
endmodule
`default_nettype wire

// File: src/ips_pkg.sv
/*
 * Package for the read-only sensor serial slave: address, byte layout,
 * sampling and refresh timing constants.
 * Assumes a 250 MHz system clock sampling the bus pins.
 */
`default_nettype none
package ips_pkg;
  localparam logic [6:0] IPS_DEV_ADDR = 7'h78;
  localparam logic IPS_DIR_READ = 1'b1;
  localparam int IPS_BYTE_BITS = 8;
  localparam logic [3:0] IPS_BIT_LAST = 4'h7;
  localparam logic [3:0] IPS_BIT_ZERO = 4'h0;
  localparam int IPS_VAL_BITS = 15;
  localparam int IPS_CLK_MHZ = 250;
  localparam int IPS_REFRESH_US_X10 = 22;
  // tenths of a millisecond times cycles per tenth of a millisecond
  localparam int IPS_REFRESH_CYC = IPS_REFRESH_US_X10 * 100 * IPS_CLK_MHZ;
  localparam logic [1:0] IPS_WORD_PH = 2'h0;
  localparam logic [1:0] IPS_WORD_PL = 2'h1;
  localparam logic [1:0] IPS_WORD_TH = 2'h2;
  localparam logic [1:0] IPS_WORD_TL = 2'h3;
  typedef enum logic [4:0] {
    IPS_IDLE = 5'b00001,
    IPS_ADDR = 5'b00010,
    IPS_AACK = 5'b00100,
    IPS_SEND = 5'b01000,
    IPS_MACK = 5'b10000
  } ips_state_e;
endpackage
`default_nettype wire

// File: src/ips_bus_if.sv
/*
 * Interface carrying the conditioned bus events from the pin front end to
 * the protocol engine. Assumes both ends run on the same system clock.
 */
`default_nettype none
interface ips_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic scl_level;
  logic sda_level;
  logic start_seen;
  logic stop_seen;
  modport front (output scl_rise, output scl_fall, output scl_level, output sda_level,
    output start_seen, output stop_seen);
  modport engine (input scl_rise, input scl_fall, input scl_level, input sda_level,
    input start_seen, input stop_seen);
endinterface
`default_nettype wire

// File: src/ips_pin_sync.sv
/*
 * Pin front end: three-stage synchronisers for the clock and data pins,
 * edge detection and START/STOP recognition.
 * Assumes the pins are asynchronous to clock_i and far slower than it.
 */
`default_nettype none
module ips_pin_sync
  import ips_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  ips_bus_if.front bus
);
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_state_reg;
  logic sda_state_reg;
  wire scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
  wire sda_agree = sda_sync_reg[1] == sda_sync_reg[2];
  wire scl_next = scl_agree ? scl_sync_reg[2] : scl_state_reg;
  wire sda_next = sda_agree ? sda_sync_reg[2] : sda_state_reg;

  // idle level is high on both lines
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_state_reg <= 1'b1;
      sda_state_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_state_reg <= scl_next;
      sda_state_reg <= sda_next;
    end
  end

  assign bus.scl_level = scl_state_reg;
  assign bus.sda_level = sda_state_reg;
  assign bus.scl_rise = !scl_state_reg && scl_next;
  assign bus.scl_fall = scl_state_reg && !scl_next;
  // data edges while clock stays high are conditions, not data
  assign bus.start_seen = scl_state_reg && scl_next && sda_state_reg && !sda_next;
  assign bus.stop_seen = scl_state_reg && scl_next && !sda_state_reg && sda_next;
endmodule
`default_nettype wire

// File: src/ips_refresh.sv
/*
 * Refresh timer: latches new pressure and temperature words from the
 * measurement core once per update interval, never in mid-word.
 * Assumes the core's words are stable on clock_i.
 */
`default_nettype none
module ips_refresh
  import ips_pkg::*;
#(
  parameter int REFRESH_CYC = IPS_REFRESH_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic [IPS_VAL_BITS-1:0] press_i,
  input wire logic [IPS_VAL_BITS-1:0] temp_i,
  output logic [IPS_VAL_BITS-1:0] press_o,
  output logic [IPS_VAL_BITS-1:0] temp_o,
  output logic tick_o
);
  logic [31:0] count_reg;
  logic pending_reg;
  wire expire = count_reg == 32'(REFRESH_CYC - 1);
  wire take = (expire || pending_reg) && !hold_i;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 32'h0;
      pending_reg <= 1'b0;
      press_o <= '0;
      temp_o <= '0;
      tick_o <= 1'b0;
    end else begin
      count_reg <= expire ? 32'h0 : count_reg + 32'h1;
      pending_reg <= (expire || pending_reg) && hold_i;
      tick_o <= take;
      if (take) begin
        press_o <= press_i;
        temp_o <= temp_i;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/ips_i2c_master.sv
/*
 * Bus master model: START, STOP, bit and byte tasks at 80 ns per bit.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
`default_nettype none
module ips_i2c_master (
  input wire logic scl_line_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // both lines released while no transfer runs
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // also serves as repeated START
  task automatic start();
    sda_o = 1'b1;
    #20;
    scl_o = 1'b1;
    #20;
    sda_o = 1'b0;
    #20;
    scl_o = 1'b0;
    #20;
  endtask
  // ends the transfer after a NACK
  task automatic stop();
    sda_o = 1'b0;
    #20;
    scl_o = 1'b1;
    #20;
    sda_o = 1'b1;
    #40;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #20;
    scl_o = 1'b1;
    wait (scl_line_i === 1'b1);
    #20;
    r = sda_line_i;
    #20;
    scl_o = 1'b0;
    #20;
  endtask
  task automatic byte_wr(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic byte_rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule
`default_nettype wire

// File: verif/ips_sensor_slave_assertions.sv
/*
 * Checker on the sensor slave's top ports, bound into every instance.
 * Assumes one clock domain and an active-high reset.
 */
`default_nettype none
module ips_sensor_slave_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic busy_o,
  input wire logic addressed_o,
  input wire logic refresh_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_idle_released: assert property (!busy_o && !$past(busy_o) |-> sda_oe_n_o && scl_oe_n_o)
    else $error("line driven on idle bus");
  a_drive_low: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("data driven high");
  a_change_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data changed with clock high");
  a_bit_stable: assert property ($rose(scl_i) |-> $stable(sda_oe_n_o) [*8])
    else $error("data moved in clock high");
  a_start_busy: assert property ($fell(sda_i) && scl_i |-> ##[1:8] busy_o)
    else $error("start not seen");
  a_stop_idle: assert property ($rose(sda_i) && scl_i |-> ##[1:8] !busy_o && !addressed_o)
    else $error("stop not seen");
  a_served_busy: assert property (addressed_o |-> busy_o || $past(busy_o))
    else $error("serving on idle bus");
  a_ack_match: assert property ($fell(sda_oe_n_o) |-> ##[0:40] addressed_o)
    else $error("drive without match");
  a_refresh_pulse: assert property (refresh_o |=> !refresh_o)
    else $error("refresh pulse too long");
  a_stretch_short: assert property (!scl_oe_n_o |-> !scl_o ##1 scl_oe_n_o)
    else $error("clock held too long");
  c_busy: cover property ($rose(busy_o));
  c_served: cover property ($rose(addressed_o));
  c_drive: cover property ($fell(sda_oe_n_o) && addressed_o);
endmodule
bind ips_sensor_slave ips_sensor_slave_chk i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .busy_o(busy_o),
  .addressed_o(addressed_o), .refresh_o(refresh_o));
`default_nettype wire

// File: verif/test_ips_sensor_slave.sv
/*
 * Self-checking bench for the sensor slave with a bus master model.
 * Assumes pull-ups on both lines and a 200-cycle refresh interval.
 */
`default_nettype none
module test_ips_sensor_slave import ips_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [IPS_VAL_BITS-1:0] press_i = 15'h0000;
  logic [IPS_VAL_BITS-1:0] temp_i = 15'h0000;
  logic [IPS_VAL_BITS-1:0] ep = 15'h0000;
  logic [IPS_VAL_BITS-1:0] et = 15'h0000;
  logic sda_o, sda_oe_n_o, scl_o, scl_oe_n_o, busy_o, addressed_o, refresh_o, m_scl, m_sda;
  int fails = 0;
  int tests_run = 0;
  wire logic sda_w = (sda_oe_n_o | sda_o) & m_sda;
  wire logic scl_w = (scl_oe_n_o | scl_o) & m_scl;
  ips_sensor_slave i_dut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
    .press_i(press_i), .temp_i(temp_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .busy_o(busy_o), .addressed_o(addressed_o),
    .refresh_o(refresh_o));
  ips_i2c_master i_mst (.scl_line_i(scl_w), .sda_line_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  // short refresh interval so that reads see live values
  defparam i_dut.u_refresh.REFRESH_CYC = 200;
  initial forever #2 clock_i = ~clock_i;
  // words offered for reading follow each refresh pulse
  always @(posedge clock_i) begin
    if (refresh_o === 1'b1) begin
      ep <= press_i;
      et <= temp_i;
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] ebyte(input int k);
    case (k % 4)
      0: return {1'b0, ep[14:8]};
      1: return ep[7:0];
      2: return {1'b0, et[14:8]};
      default: return et[7:0];
    endcase
  endfunction
  task automatic t_idle();
    check("idle lines", {5'h00, sda_oe_n_o, scl_oe_n_o, busy_o}, 8'h06);
  endtask
  task automatic t_read();
    logic nak;
    logic [7:0] d;
    i_mst.start();
    i_mst.byte_wr({IPS_DEV_ADDR, IPS_DIR_READ}, nak);
    check("addr ack", {7'h00, nak}, 8'h00);
    check("busy served", {6'h00, busy_o, addressed_o}, 8'h03);
    for (int k = 0; k < 6; k++) begin
      i_mst.byte_rd(k == 5, d);
      check("data byte", d, ebyte(k));
    end
    i_mst.stop();
    check("after stop", {6'h00, busy_o, addressed_o}, 8'h00);
  endtask
  task automatic t_refuse();
    logic nak;
    logic [7:0] d;
    logic [7:0] bad [3] = '{8'hF3, 8'hF0, 8'h71};
    for (int i = 0; i < 3; i++) begin
      i_mst.start();
      i_mst.byte_wr(bad[i], nak);
      check("bad addr ack", {7'h00, nak}, 8'h01);
      i_mst.byte_rd(1'b1, d);
      check("bus released", d, 8'hFF);
    end
    i_mst.stop();
  endtask
  task automatic t_rstart();
    logic nak;
    logic [7:0] d;
    i_mst.start();
    i_mst.byte_wr({IPS_DEV_ADDR, IPS_DIR_READ}, nak);
    i_mst.byte_rd(1'b0, d);
    check("first byte", d, ebyte(0));
    i_mst.byte_rd(1'b1, d);
    check("nack byte", d, ebyte(1));
    i_mst.start();
    i_mst.byte_wr({IPS_DEV_ADDR, IPS_DIR_READ}, nak);
    check("restart ack", {7'h00, nak}, 8'h00);
    i_mst.byte_rd(1'b1, d);
    check("restart byte", d, ebyte(0));
    i_mst.stop();
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    press_i <= 15'h5A3C;
    temp_i <= 15'h2B71;
    repeat (4) @(posedge clock_i);
    wait (refresh_o === 1'b1);
    repeat (2) @(posedge clock_i);
    t_idle();
    t_read();
    t_refuse();
    t_rstart();
    results();
  end
  initial begin
    #100us;
    fails++;
    results();
  end
endmodule
`default_nettype wire
